/* rtl/frequency_ramp_sequencer.sv */
// Purpose: frequency ramp sequencer driving divider and modulator value
// Assumes: pclk is the phase-detector clock; APB slave, zero wait states
// Notes: divide value is 12-bit integer over 25-bit fraction
// Function
// - hop equals deviation word shifted by exponent
// - hop interval is product of two dividers
// - hop count comes from 20-bit step value
// - burst adds per interval then holds
// - single sawtooth restores start then holds
// - repeating sawtooth loops until disabled
// - triangle alternates up and down runs
// - dual bit gives two independent ramps
// - deviation fields and set select layout
// - step field and set select layout
// - reprogram idle ramp without disturbing other
// - keying bit superimposes set one deviation
// - code 01 triangle, 11 single burst
// - keying adds or subtracts per transmit data
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "ramp_seq_params.svh"
module frequency_ramp_sequencer #(
   parameter int STEP_W = 20,
   parameter int TIMER_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_data,
   output logic [11:0] divide_int,
   output logic [24:0] divide_frac,
   output logic ramp_active
);

   logic [31:0] cfg_reg [0:`CFG_COUNT-1];
   logic [15:0] dev_word_reg [0:1];
   logic [3:0] dev_exp_reg [0:1];
   logic [STEP_W-1:0] step_set_reg [0:1];
   logic [31:0] rdata_reg;
   logic [36:0] acc_reg;
   logic [36:0] divide_reg;
   logic [STEP_W-1:0] step_cnt_reg;
   logic ramp_sel_reg;
   logic [2*TIMER_W-1:0] timer_reg;
   ramp_seq_pkg::ramp_state_t state_reg;
   ramp_seq_pkg::waveform_t wave;
   logic [4:0] dec;
   logic hit;
   logic [3:0] idx;
   logic wr_en;
   logic dev_wr;
   logic step_wr;
   logic ramp_start;
   logic dual_en;
   logic fsk_en;
   logic cur_set;
   logic done;
   logic tick;
   logic [36:0] base;
   logic [36:0] inc;
   logic [36:0] inc_a;
   logic [36:0] inc_b;
   logic [36:0] key_inc;
   logic [2*TIMER_W-1:0] interval;
   logic [2*TIMER_W-1:0] interval_m1;
   logic [STEP_W-1:0] step_target;

   // Address decode: {hit, index}; word aligned, up to the last status word
   function automatic logic [4:0] decode_addr(input logic [7:0] a);
      logic ok;
      ok = (a[1:0] == 2'h0) && (a[7:6] == 2'h0) && (a[5:2] <= `LAST_INDEX);
      decode_addr = {ok, a[5:2]};
   endfunction

   // Hop size: signed deviation word scaled by two to the exponent
   function automatic logic [36:0] hop_amt(input logic [15:0] w, input logic [3:0] e);
      hop_amt = {{21{w[15]}}, w} << e;
   endfunction

   assign dec = decode_addr(paddr);
   assign hit = dec[4];
   assign idx = dec[3:0];
   assign wr_en = psel && penable && pwrite && hit && (idx < 4'h8);
   assign dev_wr = wr_en && (idx == 4'(`OFF_DEV >> 2));
   assign step_wr = wr_en && (idx == 4'(`OFF_STEP >> 2));

   // Always ready; writes to read-only or unmapped words are flagged
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!hit || (pwrite && (idx >= 4'h8)));
   assign prdata = rdata_reg;

   // Live controls decoded from the stored words
   assign ramp_start = cfg_reg[0][`START_BIT];
   assign wave = ramp_seq_pkg::waveform_t'(cfg_reg[3][`WAVE_HI:`WAVE_LO]);
   assign dual_en = cfg_reg[5][`DUAL_BIT];
   assign fsk_en = cfg_reg[5][`FSK_BIT];
   assign base = {cfg_reg[0][`INT_HI:`INT_LO], cfg_reg[0][`FMSB_HI:`FMSB_LO],
                  cfg_reg[1][`FLSB_HI:`FLSB_LO]};
   assign ramp_active = (state_reg != ramp_seq_pkg::ST_IDLE);

   // Configuration words; write takes effect in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `CFG_COUNT; i++) begin
            cfg_reg[i] <= `REG_RESET;
         end
      end else if (wr_en) begin
         cfg_reg[idx[2:0]] <= pwdata;
      end
   end

   // Two deviation and step sets; select bit steers which one loads
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_set
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               dev_word_reg[g] <= 16'h0000;
               dev_exp_reg[g] <= 4'h0;
            end else if (dev_wr && (pwdata[`SET_SEL_BIT] == 1'(g))) begin
               dev_word_reg[g] <= pwdata[`DW_HI:`DW_LO];
               dev_exp_reg[g] <= pwdata[`DE_HI:`DE_LO];
            end
         end

         // Only the addressed set changes, so a running set is untouched
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               step_set_reg[g] <= '0;
            end else if (step_wr && (pwdata[`SET_SEL_BIT] == 1'(g))) begin
               step_set_reg[g] <= STEP_W'(pwdata[`STEP_HI:`STEP_LO]);
            end
         end
      end
   endgenerate

   // Read data latched in the setup phase, held through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (!hit) begin
            rdata_reg <= 32'h0000_0000;
         end else if (idx < 4'h8) begin
            rdata_reg <= cfg_reg[idx[2:0]];
         end else if (idx == 4'(`OFF_STATUS >> 2)) begin
            rdata_reg <= 32'({ramp_sel_reg, state_reg, step_cnt_reg});
         end else if (idx == 4'(`OFF_DIV_INT >> 2)) begin
            rdata_reg <= 32'(divide_reg[36:25]);
         end else begin
            rdata_reg <= 32'(divide_reg[24:0]);
         end
      end
   end

   // Active set: ramp two in the second half of a dual sweep, else set zero
   assign cur_set = dual_en && ramp_sel_reg;
   assign inc_a = hop_amt(dev_word_reg[0], dev_exp_reg[0]);
   assign inc_b = hop_amt(dev_word_reg[1], dev_exp_reg[1]);
   assign inc = cur_set ? inc_b : inc_a;
   assign key_inc = inc_b;
   assign step_target = cur_set ? step_set_reg[1] : step_set_reg[0];
   assign done = (step_cnt_reg == step_target);

   // Interval is divider a times divider b; zero is treated as one period
   assign interval = cfg_reg[2][`TDA_HI:`TDA_LO] * cfg_reg[4][`TDB_HI:`TDB_LO];
   assign interval_m1 = (interval == '0) ? '0 : interval - 1'b1;
   assign tick = (state_reg != ramp_seq_pkg::ST_IDLE) && (timer_reg >= interval_m1);

   // Hop timer; restarts whenever the ramp is idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_reg <= '0;
      end else if (state_reg == ramp_seq_pkg::ST_IDLE || tick) begin
         timer_reg <= '0;
      end else begin
         timer_reg <= timer_reg + 1'b1;
      end
   end

   // Sweep sequencer; the tick that ends a run performs the next phase's first action
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ramp_seq_pkg::ST_IDLE;
         acc_reg <= '0;
         step_cnt_reg <= '0;
         ramp_sel_reg <= 1'b0;
      end else if (!ramp_start) begin
         state_reg <= ramp_seq_pkg::ST_IDLE;
         acc_reg <= base;
         step_cnt_reg <= '0;
         ramp_sel_reg <= 1'b0;
      end else if (state_reg == ramp_seq_pkg::ST_IDLE) begin
         state_reg <= ramp_seq_pkg::ST_UP;
         acc_reg <= base;
      end else if (tick) begin
         case (state_reg)
            ramp_seq_pkg::ST_UP: begin
               if (!done) begin
                  acc_reg <= acc_reg + inc;
                  step_cnt_reg <= step_cnt_reg + 1'b1;
               end else if (dual_en && !ramp_sel_reg) begin
                  ramp_sel_reg <= 1'b1;
                  acc_reg <= acc_reg + inc_b;
                  step_cnt_reg <= STEP_W'(1);
               end else begin
                  case (wave)
                     ramp_seq_pkg::WAVE_BURST: begin
                        state_reg <= ramp_seq_pkg::ST_HOLD;
                     end
                     ramp_seq_pkg::WAVE_SAW_ONCE: begin
                        acc_reg <= base;
                        state_reg <= ramp_seq_pkg::ST_HOLD;
                     end
                     ramp_seq_pkg::WAVE_SAW: begin
                        acc_reg <= base;
                        step_cnt_reg <= '0;
                        ramp_sel_reg <= 1'b0;
                     end
                     ramp_seq_pkg::WAVE_TRI: begin
                        state_reg <= ramp_seq_pkg::ST_DOWN;
                        acc_reg <= acc_reg - inc;
                        step_cnt_reg <= STEP_W'(1);
                     end
                     default: begin
                        state_reg <= ramp_seq_pkg::ST_HOLD;
                     end
                  endcase
               end
            end
            ramp_seq_pkg::ST_DOWN: begin
               if (!done) begin
                  acc_reg <= acc_reg - inc;
                  step_cnt_reg <= step_cnt_reg + 1'b1;
               end else if (dual_en && ramp_sel_reg) begin
                  ramp_sel_reg <= 1'b0;
                  acc_reg <= acc_reg - inc_a;
                  step_cnt_reg <= STEP_W'(1);
               end else begin
                  state_reg <= ramp_seq_pkg::ST_UP;
                  acc_reg <= acc_reg + inc;
                  step_cnt_reg <= STEP_W'(1);
               end
            end
            ramp_seq_pkg::ST_HOLD: begin
               state_reg <= ramp_seq_pkg::ST_HOLD;
            end
            default: begin
               state_reg <= ramp_seq_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Output value; keying only rides on a running ramp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divide_reg <= '0;
      end else if (fsk_en && ramp_active) begin
         divide_reg <= tx_data ? acc_reg + key_inc : acc_reg - key_inc;
      end else begin
         divide_reg <= acc_reg;
      end
   end

   assign divide_int = divide_reg[36:25];
   assign divide_frac = divide_reg[24:0];

   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   hop_add_a: assert property (
      state_reg == ramp_seq_pkg::ST_UP && ramp_start && tick && !done
      |=> acc_reg == $past(acc_reg) + $past(inc))
      else $error("up hop did not add the increment");

   timer_tick_a: assert property (
      tick |-> timer_reg == interval_m1)
      else $error("hop tick not at divider product");

   burst_hold_a: assert property (
      state_reg == ramp_seq_pkg::ST_HOLD && ramp_start ##1 ramp_start
      |-> $stable(acc_reg))
      else $error("held value moved");

   saw_restore_a: assert property (
      state_reg == ramp_seq_pkg::ST_UP && ramp_start && tick && done && !dual_en
      && wave == ramp_seq_pkg::WAVE_SAW_ONCE
      |=> acc_reg == $past(base) && state_reg == ramp_seq_pkg::ST_HOLD)
      else $error("single sawtooth did not restore and hold");

   saw_loop_a: assert property (
      state_reg == ramp_seq_pkg::ST_UP && ramp_start && tick && done && !dual_en
      && wave == ramp_seq_pkg::WAVE_SAW
      |=> acc_reg == $past(base) && step_cnt_reg == '0 && state_reg == ramp_seq_pkg::ST_UP)
      else $error("sawtooth did not restart");

   tri_down_a: assert property (
      state_reg == ramp_seq_pkg::ST_DOWN && ramp_start && tick && !done
      |=> acc_reg == $past(acc_reg) - $past(inc))
      else $error("down hop did not subtract");

   dev_load_a: assert property (
      dev_wr && pwdata[`SET_SEL_BIT]
      |=> dev_word_reg[1] == $past(pwdata[`DW_HI:`DW_LO]) && $stable(dev_word_reg[0]))
      else $error("deviation set select misloaded");

   step_keep_a: assert property (
      step_wr && pwdata[`SET_SEL_BIT] |=> $stable(step_set_reg[0]))
      else $error("step write disturbed the other set");

   stop_return_a: assert property (
      !ramp_start |=> state_reg == ramp_seq_pkg::ST_IDLE && acc_reg == $past(base))
      else $error("stop did not return to programmed value");

   key_apply_a: assert property (
      fsk_en && ramp_active && !tx_data
      |=> divide_reg == $past(acc_reg) - $past(key_inc))
      else $error("keying offset wrong");

   dual_switch_a: assert property (
      dual_en && !ramp_sel_reg && state_reg == ramp_seq_pkg::ST_UP && ramp_start && tick && done
      |=> ramp_sel_reg && step_cnt_reg == STEP_W'(1))
      else $error("dual sweep did not move to ramp two");

   tri_turn_c: cover property (
      state_reg == ramp_seq_pkg::ST_UP ##1 state_reg == ramp_seq_pkg::ST_DOWN);
   burst_end_c: cover property (
      state_reg == ramp_seq_pkg::ST_UP ##1 state_reg == ramp_seq_pkg::ST_HOLD);
   dual_run_c: cover property (dual_en && ramp_sel_reg && tick);
   key_ramp_c: cover property (fsk_en && ramp_active && $rose(tx_data));

endmodule // frequency_ramp_sequencer

/* shared/ramp_seq_params.svh */
// Purpose: offsets, field positions, reset values of the ramp sequencer
// Assumes: APB word registers, byte address = index * 4
// Notes: definitions only
`ifndef RAMP_SEQ_PARAMS_SVH
`define RAMP_SEQ_PARAMS_SVH

`define OFF_INTFRAC 8'h00
`define OFF_FRAC_LOW 8'h04
`define OFF_RDIV 8'h08
`define OFF_FUNC 8'h0C
`define OFF_TEST 8'h10
`define OFF_DEV 8'h14
`define OFF_STEP 8'h18
`define OFF_DELAY 8'h1C
`define OFF_STATUS 8'h20
`define OFF_DIV_INT 8'h24
`define OFF_DIV_FRAC 8'h28
`define LAST_INDEX 4'hA
`define CFG_COUNT 8
`define REG_RESET 32'h0000_0000

`define START_BIT 31
`define INT_HI 26
`define INT_LO 15
`define FMSB_HI 14
`define FMSB_LO 3
`define FLSB_HI 27
`define FLSB_LO 15
`define TDA_HI 14
`define TDA_LO 3
`define TDB_HI 18
`define TDB_LO 7
`define WAVE_HI 11
`define WAVE_LO 10
`define DW_HI 18
`define DW_LO 3
`define DE_HI 22
`define DE_LO 19
`define SET_SEL_BIT 23
`define DUAL_BIT 24
`define FSK_BIT 25
`define STEP_HI 22
`define STEP_LO 3

`endif

/* shared/ramp_seq_pkg.sv */
// Purpose: types of the ramp sequencer
// Assumes: nothing
// Notes: Gray codes along idle, up, down, hold
package ramp_seq_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_UP = 2'h1,
      ST_DOWN = 2'h3,
      ST_HOLD = 2'h2
   } ramp_state_t;

   typedef enum logic [1:0] {
      WAVE_SAW = 2'h0,
      WAVE_TRI = 2'h1,
      WAVE_SAW_ONCE = 2'h2,
      WAVE_BURST = 2'h3
   } waveform_t;
endpackage

/* tb/frequency_ramp_sequencer_tb.sv */
// Purpose: self-checking bench for the ramp sequencer over APB
// Assumes: zero-wait APB slave, hop every a*b clocks with a=2, b=3
// Notes: base is integer 10, fraction 0x2000; waits are all bounded
`timescale 1ns/1ps
`include "ramp_seq_params.svh"
module frequency_ramp_sequencer_tb;
   localparam logic [36:0] BASE = {12'h00A, 25'h000_2000};
   localparam logic [31:0] R0W = 32'h0005_0008;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic tx_data = 1'b0;
   logic clr = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [11:0] divide_int;
   logic [24:0] divide_frac;
   logic ramp_active;
   logic [36:0] n_max;
   logic [36:0] n_min;
   logic [15:0] gap;
   logic [15:0] changes;
   logic [31:0] rd;
   logic er;
   int err_total = 0;
   int samples_checked = 0;

   // 50 MHz clock
   always #10 pclk = ~pclk;

   frequency_ramp_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .divide_int(divide_int),
      .divide_frac(divide_frac), .ramp_active(ramp_active));

   ramp_divider_model u_far (.pclk(pclk), .presetn(presetn), .clr(clr),
      .divide_int(divide_int), .divide_frac(divide_frac), .n_max(n_max), .n_min(n_min),
      .gap(gap), .changes(changes));

   task automatic end_sim();
      $display("Mismatches %0d, comparisons %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         $display("[FAIL] pready expected 1 seen %b", pready);
         err_total++;
         end_sim();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [36:0] ex, input logic [36:0] got);
      samples_checked++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         err_total++;
      end
   endtask

   // Bounded wait for the divider to have seen n changes
   task automatic wait_ch(input logic [15:0] n);
      for (int k = 0; k < 500 && changes !== n; k++) @(posedge pclk);
      if (changes !== n) begin
         $display("[FAIL] changes expected %h seen %h", n, changes);
         err_total++;
         end_sim();
      end
   endtask

   // Stop, program in descending order, start; then open a model window
   task automatic run(input logic [1:0] wv, input logic [31:0] dv0, input logic [31:0] dv1,
                      input logic [31:0] st0, input logic [31:0] st1);
      apb(1'b1, `OFF_INTFRAC, R0W);
      apb(1'b1, `OFF_DELAY, 32'h0000_0000);
      apb(1'b1, `OFF_STEP, st0);
      apb(1'b1, `OFF_STEP, st1 | 32'h0080_0000);
      apb(1'b1, `OFF_DEV, dv0);
      apb(1'b1, `OFF_DEV, dv1 | 32'h0080_0000);
      apb(1'b1, `OFF_TEST, 32'h0000_0180);
      apb(1'b1, `OFF_FUNC, {20'h0_0000, wv, 10'h000});
      apb(1'b1, `OFF_RDIV, 32'h0000_0010);
      apb(1'b1, `OFF_FRAC_LOW, 32'h0000_0000);
      apb(1'b1, `OFF_INTFRAC, R0W | 32'h8000_0000);
      repeat (2) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      // Let the cleared count settle so a stale count cannot end a wait early
      @(posedge pclk);
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      chk("reset value", 37'h0, {divide_int, divide_frac});
      presetn <= 1'b1;
      // Access errors and reset state
      apb(1'b0, `OFF_STATUS, 32'h0000_0000);
      chk("status", 37'h0, 37'(rd));
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped err", 37'h1, 37'(er));
      chk("unmapped data", 37'h0, 37'(rd));
      apb(1'b1, `OFF_DIV_INT, 32'h0000_00FF);
      chk("ro write err", 37'h1, 37'(er));
      apb(1'b0, 8'h05, 32'h0000_0000);
      chk("misaligned err", 37'h1, 37'(er));
      // Burst: hop 3<<2, three hops, then hold
      run(2'b11, 32'h0010_0018, 32'h0, 32'h0000_0018, 32'h0);
      wait_ch(16'h0003);
      repeat (30) @(posedge pclk);
      chk("burst end", BASE + 37'd36, {divide_int, divide_frac});
      chk("burst hold", 37'h3, 37'(changes));
      chk("hop spacing", 37'h6, 37'(gap));
      chk("burst active", 37'h1, 37'(ramp_active));
      apb(1'b0, `OFF_DIV_FRAC, 32'h0000_0000);
      chk("frac readback", 37'h2024, 37'(rd));
      apb(1'b0, `OFF_TEST, 32'h0000_0000);
      chk("test readback", 37'h180, 37'(rd));
      // Single sawtooth: restore then hold
      run(2'b10, 32'h0010_0018, 32'h0, 32'h0000_0018, 32'h0);
      wait_ch(16'h0004);
      chk("saw restore", BASE, {divide_int, divide_frac});
      repeat (30) @(posedge pclk);
      chk("saw hold", 37'h4, 37'(changes));
      chk("saw peak", BASE + 37'd36, n_max);
      // Repeating sawtooth: second restore
      run(2'b00, 32'h0010_0018, 32'h0, 32'h0000_0018, 32'h0);
      wait_ch(16'h0008);
      chk("repeat restore", BASE, {divide_int, divide_frac});
      chk("repeat spacing", 37'h6, 37'(gap));
      // Triangle: first down hop after the peak
      run(2'b01, 32'h0010_0018, 32'h0, 32'h0000_0018, 32'h0);
      wait_ch(16'h0004);
      chk("tri down", BASE + 37'd24, {divide_int, divide_frac});
      wait_ch(16'h0007);
      chk("tri up again", BASE + 37'd12, {divide_int, divide_frac});
      chk("tri floor", BASE, n_min);
      // Clearing start mid-run
      apb(1'b1, `OFF_INTFRAC, R0W);
      repeat (3) @(posedge pclk);
      chk("stop value", BASE, {divide_int, divide_frac});
      chk("stop active", 37'h0, 37'(ramp_active));
      // Dual burst: +2 twice from set 0, then -4 once from set 1
      run(2'b11, 32'h0100_0010, 32'h0107_FFE0, 32'h0000_0010, 32'h0000_0008);
      wait_ch(16'h0003);
      repeat (20) @(posedge pclk);
      chk("dual end", BASE, {divide_int, divide_frac});
      chk("dual peak", BASE + 37'd4, n_max);
      // Dual triangle: down run walks set one, then set zero
      run(2'b01, 32'h0100_0010, 32'h0107_FFE0, 32'h0000_0010, 32'h0000_0008);
      wait_ch(16'h0005);
      chk("dual tri turn", BASE + 37'd2, {divide_int, divide_frac});
      // Keying of 5 over a one-hop burst
      tx_data <= 1'b1;
      run(2'b11, 32'h0010_0018, 32'h0200_0028, 32'h0000_0008, 32'h0);
      repeat (30) @(posedge pclk);
      chk("key high", BASE + 37'd17, {divide_int, divide_frac});
      tx_data <= 1'b0;
      repeat (4) @(posedge pclk);
      chk("key low", BASE + 37'd7, {divide_int, divide_frac});
      tx_data <= 1'b1;
      repeat (4) @(posedge pclk);
      chk("key high again", BASE + 37'd17, {divide_int, divide_frac});
      end_sim();
   end
endmodule // frequency_ramp_sequencer_tb

/* tb/ramp_divider_model.sv */
// Purpose: far-side divider model, watches the divide value each clock
// Assumes: modulator takes the 37-bit value on every pclk edge
// Notes: clr opens a new window for range, spacing and change count
`timescale 1ns/1ps
module ramp_divider_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic [11:0] divide_int,
   input wire logic [24:0] divide_frac,
   output logic [36:0] n_max,
   output logic [36:0] n_min,
   output logic [15:0] gap,
   output logic [15:0] changes
);
   logic [36:0] n_now;
   logic [36:0] last_reg;
   logic [15:0] run_reg;

   assign n_now = {divide_int, divide_frac};

   // Spacing in clocks between value changes; the first gap of a window is rough
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_reg <= 37'h0;
         run_reg <= 16'h0001;
         gap <= 16'h0000;
         changes <= 16'h0000;
      end else if (clr) begin
         last_reg <= n_now;
         run_reg <= 16'h0001;
         changes <= 16'h0000;
      end else begin
         last_reg <= n_now;
         if (n_now != last_reg) begin
            gap <= run_reg;
            run_reg <= 16'h0001;
            changes <= changes + 16'h0001;
         end else begin
            run_reg <= run_reg + 16'h0001;
         end
      end
   end

   // Range seen by the divider since the window opened
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_max <= 37'h0;
         n_min <= 37'h0;
      end else if (clr) begin
         n_max <= n_now;
         n_min <= n_now;
      end else begin
         if (n_now > n_max) n_max <= n_now;
         if (n_now < n_min) n_min <= n_now;
      end
   end
endmodule // ramp_divider_model
